// file: logic/sdo_defs.vh
// constants for the symbol data output gating block
// assumes inclusion by both design files of this block
`ifndef SDO_DEFS_VH
`define SDO_DEFS_VH
// register byte offsets
`define SDO_REG_CFG        12'h000
`define SDO_REG_STATUS     12'h004
`define SDO_REG_COUNT      12'h008
// configuration field positions
`define SDO_CFG_COND_LSB   0
`define SDO_CFG_COND_MSB   2
`define SDO_CFG_TIMING_BIT 4
`define SDO_CFG_SYMID_BIT  5
`define SDO_CFG_MATCH_BIT  6
`define SDO_CFG_NOREAD_BIT 7
`define SDO_CFG_DBO_LSB    8
`define SDO_CFG_DBO_MSB    15
// condition codes
`define SDO_COND_OFF       3'h0
`define SDO_COND_MATCH     3'h1
`define SDO_COND_MISMATCH  3'h2
`define SDO_COND_ANY       3'h3
`define SDO_COND_ALL       3'h4
// timing codes
`define SDO_TIME_NOW       1'b0
`define SDO_TIME_END       1'b1
// reset values: any good read, immediate, id off, no-read on, one decode
`define SDO_CFG_RESET      32'h0000_0183
// identifier length in characters
`define SDO_SYMID_LEN      2'h3
`endif

// file: logic/sdo_qualify.v
// per-symbol qualification counter
// assumes decode pulses come from the core clock domain
`timescale 1ns/1ps
`include "sdo_defs.vh"
module sdo_qualify
#(
  parameter CW = 8                      // decode count width
)
(
  input  wire          i_clk,           // core clock
  input  wire          i_rst_b,         // async reset, low
  input  wire          i_clear,         // new symbol or new cycle
  input  wire          i_decode,        // one successful decode
  input  wire [CW-1:0] i_need,          // decodes before output
  output reg           o_qualified      // one-cycle qualify pulse
);
  reg [CW-1:0] count;                   // decodes seen so far
  reg          done;                    // already qualified once
  wire [CW-1:0] need_eff = (i_need == {CW{1'b0}}) ? {{(CW-1){1'b0}}, 1'b1} : i_need;
  wire [CW-1:0] next_count = count + {{(CW-1){1'b0}}, 1'b1};

  // count decodes, pulse once when enough are seen
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      count       <= {CW{1'b0}};
      done        <= 1'b0;
      o_qualified <= 1'b0;
    end
    else if (i_clear)
    begin
      count       <= {CW{1'b0}};
      done        <= 1'b0;
      o_qualified <= 1'b0;
    end
    else
    begin
      o_qualified <= 1'b0;
      if (i_decode && !done)
      begin
        count <= next_count;
        if (next_count >= need_eff)
        begin
          done        <= 1'b1;
          o_qualified <= 1'b1;
        end
      end
    end
  end
endmodule

// file: logic/sdo_gate.v
// symbol data output gating with apb configuration
// assumes cycle and symbol events are synchronous one-cycle pulses
`timescale 1ns/1ps
`include "sdo_defs.vh"
module sdo_gate
#(
  parameter CW = 8                      // decodes-before-output width
)
(
  input  wire        I_CORE_CLK,        // core clock, 10 mhz
  input  wire        I_RST_B,           // async reset, low
  input  wire        I_PSEL,            // apb select
  input  wire        I_PENABLE,         // apb access phase
  input  wire        I_PWRITE,          // apb direction
  input  wire [11:0] I_PADDR,           // apb byte address
  input  wire [31:0] I_PWDATA,          // apb write data
  output wire        O_PREADY,          // apb ready
  output reg  [31:0] O_PRDATA,          // apb read data
  output wire        O_PSLVERR,         // apb error
  input  wire        I_CYCLE_START,     // read cycle begins
  input  wire        I_CYCLE_END,       // read cycle ends
  input  wire        I_END_TIMEOUT,     // end cause: timeout
  input  wire        I_END_TRIGGER,     // end cause: new trigger
  input  wire        I_SYM_START,       // new symbol slot begins
  input  wire        I_SYM_DECODE,      // one successful decode
  input  wire        I_SYM_MATCH,       // decode equals master
  input  wire        I_MASTER_VALID,    // master symbol stored
  output reg         O_SEND_SYM,        // pulse: send symbol data
  output reg         O_SEND_NOREAD,     // pulse: send no-read message
  output reg         O_SEND_SYMID,      // with send: add identifier
  output reg  [1:0]  O_SYMID_LEN,       // identifier characters
  output reg  [7:0]  O_SEND_COUNT,      // symbols released by pulse
  output reg         O_SEND_CAUSE       // 1 end of cycle, 0 immediate
);
  // idle and active read cycle states, one-hot
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg [31:0] cfg;                       // configuration register
  reg [1:0]  state;                     // cycle state
  reg [7:0]  held;                      // symbols pending end of cycle
  reg [7:0]  held_match;                // pending symbols that matched
  reg [7:0]  slots;                     // symbol slots in this cycle
  reg [7:0]  quals;                     // qualified symbols this cycle
  reg        slot_match;                // current slot matched
  reg [15:0] sent_total;                // count register: total sends
  reg        last_noread;               // status: last was no-read
  wire       qual;                      // qualify pulse

  wire [2:0]    cond   = cfg[`SDO_CFG_COND_MSB:`SDO_CFG_COND_LSB];
  wire          timing = cfg[`SDO_CFG_TIMING_BIT];
  wire          symid  = cfg[`SDO_CFG_SYMID_BIT];
  wire          nr_en  = cfg[`SDO_CFG_NOREAD_BIT];
  wire [CW-1:0] need   = cfg[`SDO_CFG_DBO_MSB:`SDO_CFG_DBO_LSB];
  // master filtering only when comparison enabled and master loaded
  wire          cmp_on = cfg[`SDO_CFG_MATCH_BIT] && I_MASTER_VALID;

  // apb: zero-wait slave, unmapped reads zero and error
  wire apb_acc = I_PSEL && I_PENABLE;
  wire mapped  = (I_PADDR == `SDO_REG_CFG) || (I_PADDR == `SDO_REG_STATUS) ||
                 (I_PADDR == `SDO_REG_COUNT);
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = apb_acc && !mapped;

  // decide whether a qualified symbol passes the condition filter
  function pass_sym;
    input [2:0] c;
    input       cmp;
    input       m;
    begin
      if (c == `SDO_COND_MATCH)
        pass_sym = cmp ? m : 1'b1;
      else if (c == `SDO_COND_MISMATCH)
        pass_sym = cmp ? !m : 1'b1;
      else if (c == `SDO_COND_ANY || c == `SDO_COND_ALL)
        pass_sym = 1'b1;
      else
        pass_sym = 1'b0;
    end
  endfunction

  // per-symbol decode qualification
  sdo_qualify #(.CW(CW)) u_qual
  (
    .i_clk       (I_CORE_CLK),
    .i_rst_b     (I_RST_B),
    .i_clear     (I_SYM_START | I_CYCLE_START),
    .i_decode    (I_SYM_DECODE & state[1]),
    .i_need      (need),
    .o_qualified (qual)
  );

  // slot_match already holds the decode-time match level at qualify time
  wire pass_now = pass_sym(cond, cmp_on, slot_match);
  // no-read only allowed in match, mismatch, good-read and all-good modes
  wire nr_cond  = (cond == `SDO_COND_MATCH) || (cond == `SDO_COND_MISMATCH) ||
                  (cond == `SDO_COND_ANY) || (cond == `SDO_COND_ALL);
  wire cyc_end  = state[1] && (I_CYCLE_END || I_END_TIMEOUT || I_END_TRIGGER);
  wire all_ok   = (quals == slots) && (quals != 8'h00);
  wire [7:0] pend_pass = (cond == `SDO_COND_MATCH)    ? (cmp_on ? held_match : held) :
                         (cond == `SDO_COND_MISMATCH) ? (cmp_on ? held - held_match : held) :
                         held;

  // configuration register write, reset defaults
  always @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      cfg <= `SDO_CFG_RESET;
    else if (apb_acc && I_PWRITE && I_PADDR == `SDO_REG_CFG)
      cfg <= {16'h0000, I_PWDATA[15:0] & 16'hfff7}; // bit 3 reserved, compare bit 6 kept
  end

  // apb read data
  always @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      O_PRDATA <= 32'h0000_0000;
    else if (I_PSEL && !I_PENABLE && !I_PWRITE)
    begin
      if (I_PADDR == `SDO_REG_CFG)
        O_PRDATA <= cfg;
      else if (I_PADDR == `SDO_REG_STATUS)
        O_PRDATA <= {14'h0000, last_noread, state[1], slots, quals};
      else if (I_PADDR == `SDO_REG_COUNT)
        O_PRDATA <= {16'h0000, sent_total};
      else
        O_PRDATA <= 32'h0000_0000;      // unmapped reads zero
    end
  end

  // read cycle tracking and output decisions
  always @(posedge I_CORE_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      state         <= ST_IDLE;
      held          <= 8'h00;
      held_match    <= 8'h00;
      slots         <= 8'h00;
      quals         <= 8'h00;
      slot_match    <= 1'b0;
      sent_total    <= 16'h0000;
      last_noread   <= 1'b0;
      O_SEND_SYM    <= 1'b0;
      O_SEND_NOREAD <= 1'b0;
      O_SEND_SYMID  <= 1'b0;
      O_SYMID_LEN   <= 2'h0;
      O_SEND_COUNT  <= 8'h00;
      O_SEND_CAUSE  <= 1'b0;
    end
    else
    begin
      O_SEND_SYM    <= 1'b0;
      O_SEND_NOREAD <= 1'b0;
      // set wins over the slot clear so a first-cycle match is not lost
      if (I_SYM_DECODE && I_SYM_MATCH)
        slot_match <= 1'b1;
      else if (I_SYM_START)
        slot_match <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (I_CYCLE_START)
          begin
            state      <= ST_RUN;
            held       <= 8'h00;
            held_match <= 8'h00;
            slots      <= 8'h00;
            quals      <= 8'h00;
          end
        end
        ST_RUN:
        begin
          if (I_SYM_START)
            slots <= slots + 8'h01;
          if (qual)
          begin
            quals <= quals + 8'h01;
            if (timing == `SDO_TIME_NOW && cond != `SDO_COND_ALL && pass_now)
            begin
              O_SEND_SYM   <= 1'b1;
              O_SEND_COUNT <= 8'h01;
              O_SEND_CAUSE <= 1'b0;
              O_SEND_SYMID <= symid;
              O_SYMID_LEN  <= symid ? `SDO_SYMID_LEN : 2'h0;
              sent_total   <= sent_total + 16'h0001;
              last_noread  <= 1'b0;
            end
            else
            begin
              held <= held + 8'h01;
              if (slot_match)
                held_match <= held_match + 8'h01;
            end
          end
          if (cyc_end)
          begin
            state <= ST_IDLE;
            if (quals == 8'h00 && !qual)
            begin
              if (nr_en && nr_cond)
              begin
                O_SEND_NOREAD <= 1'b1;
                O_SEND_CAUSE  <= 1'b1;
                O_SEND_SYMID  <= 1'b0;
                O_SYMID_LEN   <= 2'h0;
                O_SEND_COUNT  <= 8'h00;
                sent_total    <= sent_total + 16'h0001;
                last_noread   <= 1'b1;
              end
            end
            else if (cond != `SDO_COND_OFF && pend_pass != 8'h00 &&
                     (cond != `SDO_COND_ALL || all_ok))
            begin
              O_SEND_SYM   <= 1'b1;
              O_SEND_COUNT <= pend_pass;
              O_SEND_CAUSE <= 1'b1;
              O_SEND_SYMID <= symid;
              O_SYMID_LEN  <= symid ? `SDO_SYMID_LEN : 2'h0;
              sent_total   <= sent_total + 16'h0001;
              last_noread  <= 1'b0;
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule

// file: test/sdo_gate_monitor.sv
// checker for the symbol data output gating block
// assumes it sees only the top ports; bound below
`timescale 1ns/1ps
`include "sdo_defs.vh"
module sdo_gate_monitor
(
  input wire        I_CORE_CLK,
  input wire        I_RST_B,
  input wire        I_PSEL,
  input wire        I_PENABLE,
  input wire        I_PWRITE,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  input wire        O_PREADY,
  input wire        O_PSLVERR,
  input wire        I_CYCLE_END,
  input wire        I_END_TIMEOUT,
  input wire        I_END_TRIGGER,
  input wire        I_SYM_DECODE,
  input wire        O_SEND_SYM,
  input wire        O_SEND_NOREAD,
  input wire        O_SEND_SYMID,
  input wire [1:0]  O_SYMID_LEN,
  input wire        O_SEND_CAUSE
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);
  reg [2:0] cond; // shadow of the condition field
  reg       tim;  // shadow of the timing bit
  reg       end_seen; // any cycle end cause on the previous edge
  // any of the three end causes closes the cycle
  always @(posedge I_CORE_CLK or negedge I_RST_B)
    if (!I_RST_B)
      end_seen <= 1'b0;
    else
      end_seen <= I_CYCLE_END | I_END_TIMEOUT | I_END_TRIGGER;
  // track cfg writes so gating rules can be judged from the pins
  always @(posedge I_CORE_CLK or negedge I_RST_B)
    if (!I_RST_B)
    begin
      cond <= `SDO_COND_ANY;
      tim  <= `SDO_TIME_NOW;
    end
    else if (I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && I_PADDR == `SDO_REG_CFG)
    begin
      cond <= I_PWDATA[2:0];
      tim  <= I_PWDATA[4];
    end
  off_silent_a: assert property (cond == `SDO_COND_OFF |-> !O_SEND_SYM && !O_SEND_NOREAD)
    else $error("send while disabled");
  imm_after_dec_a: assert property (O_SEND_SYM && !O_SEND_CAUSE |-> $past(I_SYM_DECODE, 2))
    else $error("immediate send without decode");
  end_after_cyc_a: assert property (O_SEND_SYM && O_SEND_CAUSE |-> end_seen)
    else $error("end send not after cycle end");
  noread_at_end_a: assert property (O_SEND_NOREAD |-> end_seen)
    else $error("no-read not after cycle end");
  end_timing_a: assert property (tim && O_SEND_SYM |-> O_SEND_CAUSE)
    else $error("immediate send in end timing");
  all_at_end_a: assert property (cond == `SDO_COND_ALL && O_SEND_SYM |-> O_SEND_CAUSE)
    else $error("all-good send before end");
  symid_len_a: assert property (O_SEND_SYM && O_SEND_SYMID |-> O_SYMID_LEN == `SDO_SYMID_LEN)
    else $error("identifier length wrong");
  one_decision_a: assert property (!(O_SEND_SYM && O_SEND_NOREAD))
    else $error("symbol and no-read together");
  err_access_a: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
    else $error("error outside access");
  ready_high_a: assert property (O_PREADY)
    else $error("ready low");
endmodule
bind sdo_gate sdo_gate_monitor mon_u(.I_CORE_CLK, .I_RST_B, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA,
  .O_PREADY, .O_PSLVERR, .I_CYCLE_END, .I_END_TIMEOUT, .I_END_TRIGGER, .I_SYM_DECODE, .O_SEND_SYM, .O_SEND_NOREAD,
  .O_SEND_SYMID, .O_SYMID_LEN,
  .O_SEND_CAUSE);

// file: test/sdo_host_model.sv
// host side: counts messages received from the block
// assumes one-cycle send pulses on the core clock
`timescale 1ns/1ps
module sdo_host_model
(
  input  wire i_clk,    // core clock
  input  wire i_rst_b,  // async reset, low
  input  wire i_sym,    // symbol data arrives
  input  wire i_noread, // no-read message arrives
  output int  o_msgs    // messages taken so far
);
  // every pulse is one whole message to the host
  always @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      o_msgs <= 0;
    else if (i_sym || i_noread)
      o_msgs <= o_msgs + 1;
endmodule

// file: test/tb_top.sv
// self-checking bench for the symbol data output gating block
// assumes the monitor is bound and the host model counts messages
`timescale 1ns/1ps
`include "sdo_defs.vh"
module tb_top;
  logic I_CORE_CLK = 0, I_RST_B = 0, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0, I_SYM_MATCH = 0, I_MASTER_VALID = 0;
  logic [11:0] I_PADDR = 0;
  logic [31:0] I_PWDATA = 0, rd;
  logic [5:0]  evv = 0; // start,end,timeout,trigger,symbol,decode
  logic [11:0] q[$], e; // expected {sym,noread,cause,symid,count}
  logic        mfix = 0, mval = 0; // fixed match level when mfix set
  logic        er;
  wire O_PREADY, O_PSLVERR, O_SEND_SYM, O_SEND_NOREAD, O_SEND_SYMID, O_SEND_CAUSE;
  wire [31:0] O_PRDATA;
  wire [1:0]  O_SYMID_LEN;
  wire [7:0]  O_SEND_COUNT;
  int error_cnt = 0, total_checks = 0, cyc_n = 0, n_exp = 0, n_host;
  always #50 I_CORE_CLK = ~I_CORE_CLK;
  sdo_gate dut_u(.I_CORE_CLK, .I_RST_B, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PREADY, .O_PRDATA,
    .O_PSLVERR, .I_CYCLE_START(evv[5]), .I_CYCLE_END(evv[4]), .I_END_TIMEOUT(evv[3]), .I_END_TRIGGER(evv[2]),
    .I_SYM_START(evv[1]), .I_SYM_DECODE(evv[0]), .I_SYM_MATCH, .I_MASTER_VALID, .O_SEND_SYM, .O_SEND_NOREAD,
    .O_SEND_SYMID, .O_SYMID_LEN, .O_SEND_COUNT, .O_SEND_CAUSE);
  sdo_host_model host_u(.i_clk(I_CORE_CLK), .i_rst_b(I_RST_B), .i_sym(O_SEND_SYM), .i_noread(O_SEND_NOREAD),
    .o_msgs(n_host));
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] gt);
    total_checks++;
    if (gt !== ex)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, ex, gt);
    end
  endtask
  // apb master: holds the request until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge I_CORE_CLK);
    {I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} <= {2'b10, w, a, d};
    @(posedge I_CORE_CLK);
    I_PENABLE <= 1'b1;
    do @(posedge I_CORE_CLK); while (O_PREADY !== 1'b1 && cyc_n < 20000);
    rd = O_PRDATA;
    er = O_PSLVERR;
    {I_PSEL, I_PENABLE} <= 2'b00;
  endtask
  // one-cycle event pulse; match level is random noise unless mfix is set, then mval
  task ev(input logic [5:0] v);
    @(posedge I_CORE_CLK);
    evv <= v;
    I_SYM_MATCH <= mfix ? mval : 1'($urandom);
    @(posedge I_CORE_CLK);
    evv <= 6'h00;
  endtask
  // read cycle: ns slots of nd decodes, ex empty slots; ends by timeout or trigger
  task cyc(input int nd, input logic [3:0] ei, input logic [3:0] ee, input int ns = 1, input int ex = 0);
    repeat (ns) if (ei) begin q.push_back({ei, 8'h01}); n_exp++; end
    if (ee) begin q.push_back({ee, ee[2] ? 8'h00 : 8'(ns)}); n_exp++; end
    ev(6'h20);
    repeat (ns)
    begin
      ev(6'h02);
      repeat (nd) ev(6'h01);
    end
    repeat (ex) ev(6'h02);
    repeat (4) @(posedge I_CORE_CLK);
    ev($urandom % 2 ? 6'h08 : 6'h14);
    repeat (4) @(posedge I_CORE_CLK);
  endtask
  // watcher: each send pulse retires the oldest expectation
  // sampled mid-cycle, where the registered pulses have settled
  always @(negedge I_CORE_CLK)
    if (I_RST_B && (O_SEND_SYM || O_SEND_NOREAD))
    begin
      e = q.size() ? q.pop_front() : 12'h000;
      chk("send kind", e[11:8], {O_SEND_SYM, O_SEND_NOREAD, O_SEND_CAUSE, O_SEND_SYMID});
      chk("send count", e[7:0], O_SEND_COUNT);
      chk("id length", e[8] ? `SDO_SYMID_LEN : 2'h0, O_SYMID_LEN);
    end
  // hang guard, far above the few hundred cycles needed
  always @(posedge I_CORE_CLK)
  begin
    cyc_n++;
    if (cyc_n == 20000) begin error_cnt++; print_verdict; end
  end
  initial
  begin
    rd = $urandom(32'h0a54855d);
    repeat (3) @(posedge I_CORE_CLK);
    I_RST_B <= 1'b1;
    apb(0, `SDO_REG_CFG, 0);
    chk("cfg reset", `SDO_CFG_RESET, rd);
    apb(0, 12'hffc, 0);
    chk("unmapped data", 0, rd);
    chk("unmapped err", 1, er);
    $display("test registers done");
    for (int c = 0; c < 5; c++)
    begin
      apb(1, `SDO_REG_CFG, {16'($urandom), 16'h0180 | 16'(c)});
      cyc(1, (c > 0 && c < 4) ? 4'b1000 : 4'b0, c == 4 ? 4'b1010 : 4'b0);
      cyc(0, 0, c ? 4'b0110 : 4'b0);
      $display("test condition %0d done", c);
    end
    apb(1, `SDO_REG_CFG, 32'h0000_0003);
    cyc(0, 0, 0);
    apb(1, `SDO_REG_CFG, 32'h0000_0133);
    cyc(1, 0, 4'b1011);
    apb(1, `SDO_REG_CFG, 32'h0000_0283);
    cyc(1, 0, 4'b0110);
    apb(0, `SDO_REG_STATUS, 0);
    chk("status", 32'h0002_0100, rd);
    cyc(2, 4'b1000, 0);
    $display("test timing and qualify done");
    mfix = 1;
    apb(1, `SDO_REG_CFG, 32'h0000_01c1);
    cyc(1, 4'b1000, 0);
    I_MASTER_VALID <= 1'b1;
    cyc(1, 0, 0);
    mval = 1;
    cyc(1, 4'b1000, 0);
    apb(1, `SDO_REG_CFG, 32'h0000_01c2);
    cyc(1, 0, 0);
    mval = 0;
    cyc(1, 4'b1000, 0);
    apb(1, `SDO_REG_CFG, 32'h0000_01d2);
    cyc(1, 0, 4'b1010, 2);
    mval = 1;
    cyc(1, 0, 0, 2);
    apb(1, `SDO_REG_CFG, 32'h0000_0184);
    cyc(1, 0, 0, 1, 1);
    cyc(1, 0, 4'b1010, 2);
    $display("test compare and all-good done");
    apb(0, `SDO_REG_COUNT, 0);
    chk("send total", n_exp, rd);
    chk("left expected", 0, q.size());
    chk("host messages", n_exp, n_host);
    print_verdict;
  end
endmodule
